// ===== csp_pkg.sv
// Purpose: Shared constants and types for the codec serial control port
// Assumes: 8-bit internal registers, 7-bit register addresses
// Notes:   Avalon word index equals the 7-bit register address
package csp_pkg;

  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 8;
  localparam int AV_DATA_W  = 32;
  localparam int GP_REGS    = 16;

  // Frame layout, counted in serial clock rising edges from zero
  localparam logic [3:0] CNT_ADDR_LAST = 4'h6;
  localparam logic [3:0] CNT_RW_BIT    = 4'h7;
  localparam logic [3:0] CNT_DATA_FRST = 4'h8;
  localparam logic [3:0] CNT_FRAME_END = 4'hF;

  // Register map
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 7'h20;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 7'h21;
  localparam logic [ADDR_W-1:0] REG_SRC_ERROR  = 7'h22;
  localparam logic [ADDR_W-1:0] REG_RX_ERROR   = 7'h23;
  localparam logic [ADDR_W-1:0] REG_DAC_CTRL4  = 7'h24;

  // Field positions
  localparam int STAT_SRC_ERR_BIT = 0;
  localparam int STAT_RX_ERR_BIT  = 1;
  localparam int STAT_MISC_LSB    = 2;
  localparam int IRQ_PIN_SEL_BIT  = 0;

  // Reset values
  localparam logic [DATA_W-1:0] GP_RST     = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RST   = 8'h00;
  localparam logic [DATA_W-1:0] ERR_RST    = 8'h00;
  localparam logic              PINSEL_RST = 1'b0;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } csp_wr_t;

  typedef struct packed {
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] rx;
    logic [5:0]        misc;
  } csp_evt_t;

endpackage

// ===== csp_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Each bit is a slow level relative to clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module csp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

// ===== csp_ctrl_port.sv
// Purpose: Serial control port with register file and interrupt logic
// Assumes: Serial clock from the host, oversampled by clk_i at 40 MHz
// Notes:   Serial clock high and low phases must each last 3+ clk_i cycles
`timescale 1ns/100ps

//
// Contract
// - A single-register transfer is sixteen serial clock bits.
// - A transfer starts when the latch falls and bit counting begins there.
// - The first seven bits after the latch falls are the register address.
// - A low eighth bit makes a write of the next eight bits to that address.
// - A high eighth bit shifts the register out over the next eight clocks.
// - In a read, input bits after the read/write bit are ignored.
// - In a block write the address increments after each sixteenth bit.
// - In a block read the address increments and the next register follows.
// - Every register reached through the port is eight bits wide.
// - Interrupt status bits are sticky until the status register is read.
// - An interrupt is raised for a condition only if its mask bit is one.
// - Two summary bits flag converter and receiver errors with own registers.
// - The pin select bit routes zero-flag (0) or interrupt (1) to the pin.
module csp_ctrl_port
  import csp_pkg::*;
#(
  parameter int NUM_GP = GP_REGS
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ctrl_latch_n_i,
  input  wire logic                 ctrl_serial_clock_i,
  input  wire logic                 ctrl_serial_in_i,
  output logic                      ctrl_serial_out_o,
  output logic                      ctrl_serial_out_oe_o,
  input  wire logic [ADDR_W-1:0]    avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [AV_DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output logic      [AV_DATA_W-1:0] avs_readdata_o,
  output logic                      avs_waitrequest_o,
  input  wire csp_evt_t             evt_i,
  input  wire logic                 zero_left_i,
  output logic                      irq_o,
  output logic                      zero_left_or_irq_pin_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA
  } csp_state_t;

  // Synchronised pins
  logic [2:0]        pins_sync;
  logic              s_latch_n;
  logic              s_sclk;
  logic              s_mosi;
  logic              sclk_d_reg;
  logic              sclk_rise;
  logic              sclk_fall;

  // Serial frame state
  csp_state_t        state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] shin_reg;
  logic [DATA_W-1:0] shout_reg;

  // Register file
  logic [DATA_W-1:0] gp_reg [NUM_GP];
  logic [DATA_W-1:0] status_reg;
  logic [DATA_W-1:0] status_next;
  logic [DATA_W-1:0] mask_reg;
  logic [DATA_W-1:0] src_err_reg;
  logic [DATA_W-1:0] src_err_next;
  logic [DATA_W-1:0] rx_err_reg;
  logic [DATA_W-1:0] rx_err_next;
  logic              pin_sel_reg;

  // Access strobes
  csp_wr_t           spi_wr;
  csp_wr_t           av_wr;
  logic              spi_rd_load;
  logic [ADDR_W-1:0] spi_rd_addr;
  logic              av_rd_take;

  csp_sync #(
    .W (3)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({ctrl_latch_n_i, ctrl_serial_clock_i, ctrl_serial_in_i}),
    .q_o   (pins_sync)
  );

  assign s_latch_n = pins_sync[2];
  assign s_sclk    = pins_sync[1];
  assign s_mosi    = pins_sync[0];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= s_sclk;
    end
  end

  // Edges only count inside a frame
  assign sclk_rise = ~s_latch_n & s_sclk & ~sclk_d_reg;
  assign sclk_fall = ~s_latch_n & ~s_sclk & sclk_d_reg;

  // Read mux, reserved bits read as zero
  function automatic logic [DATA_W-1:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = '0;
    if (int'(a) < NUM_GP) begin
      v = gp_reg[int'(a)];
    end else begin
      case (a)
        REG_IRQ_STATUS: v = status_reg;
        REG_IRQ_MASK:   v = mask_reg;
        REG_SRC_ERROR:  v = src_err_reg;
        REG_RX_ERROR:   v = rx_err_reg;
        REG_DAC_CTRL4:  v[IRQ_PIN_SEL_BIT] = pin_sel_reg;
        default:        v = '0;
      endcase
    end
    return v;
  endfunction

  // Frame sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= '0;
      addr_reg    <= '0;
      shin_reg    <= '0;
    end else if (s_latch_n) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= '0;
      shin_reg    <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg   <= ST_ADDR;
          bit_cnt_reg <= '0;
        end
        ST_ADDR: begin
          if (sclk_rise) begin
            shin_reg    <= {shin_reg[DATA_W-2:0], s_mosi};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == CNT_ADDR_LAST) begin
              addr_reg <= {shin_reg[ADDR_W-2:0], s_mosi};
            end
            if (bit_cnt_reg == CNT_RW_BIT) begin
              state_reg <= s_mosi ? ST_RDATA : ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (sclk_rise) begin
            shin_reg <= {shin_reg[DATA_W-2:0], s_mosi};
            if (bit_cnt_reg == CNT_FRAME_END) begin
              addr_reg    <= addr_reg + 7'h01;
              bit_cnt_reg <= CNT_DATA_FRST;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_RDATA: begin
          // Input line is not sampled here
          if (sclk_rise) begin
            if (bit_cnt_reg == CNT_FRAME_END) begin
              addr_reg    <= addr_reg + 7'h01;
              bit_cnt_reg <= CNT_DATA_FRST;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Serial write commit on the sixteenth bit
  always_comb begin
    spi_wr.en   = (state_reg == ST_WDATA) && sclk_rise &&
                  (bit_cnt_reg == CNT_FRAME_END);
    spi_wr.addr = addr_reg;
    spi_wr.data = {shin_reg[DATA_W-2:0], s_mosi};
  end

  // Serial read load: after the R/W bit, and after each sixteenth bit
  always_comb begin
    spi_rd_load = 1'b0;
    spi_rd_addr = addr_reg;
    if (sclk_rise && (state_reg == ST_ADDR) &&
        (bit_cnt_reg == CNT_RW_BIT) && s_mosi) begin
      spi_rd_load = 1'b1;
    end else if (sclk_rise && (state_reg == ST_RDATA) &&
                 (bit_cnt_reg == CNT_FRAME_END)) begin
      spi_rd_load = 1'b1;
      spi_rd_addr = addr_reg + 7'h01;
    end
  end

  // Serial output shifter, changes on falling serial edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shout_reg            <= '0;
      ctrl_serial_out_o    <= 1'b0;
      ctrl_serial_out_oe_o <= 1'b0;
    end else if (s_latch_n) begin
      ctrl_serial_out_o    <= 1'b0;
      ctrl_serial_out_oe_o <= 1'b0;
    end else if (spi_rd_load) begin
      shout_reg            <= rd_mux(spi_rd_addr);
      ctrl_serial_out_oe_o <= 1'b1;
    end else if (sclk_fall && (state_reg == ST_RDATA)) begin
      ctrl_serial_out_o <= shout_reg[DATA_W-1];
      shout_reg         <= {shout_reg[DATA_W-2:0], 1'b0};
    end
  end

  // Avalon slave: one wait cycle, then the access completes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
      avs_waitrequest_o <= 1'b0;
      if (avs_read_i) begin
        avs_readdata_o <= {{(AV_DATA_W-DATA_W){1'b0}},
                           rd_mux(avs_address_i)};
      end
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  assign av_rd_take = avs_waitrequest_o && avs_read_i;

  always_comb begin
    av_wr.en   = ~avs_waitrequest_o && avs_write_i && avs_byteenable_i[0];
    av_wr.addr = avs_address_i;
    av_wr.data = avs_writedata_i[DATA_W-1:0];
  end

  // General registers; serial write wins a same-cycle same-address clash
  for (genvar g = 0; g < NUM_GP; g++) begin : g_gp
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        gp_reg[g] <= GP_RST;
      end else if (spi_wr.en && (int'(spi_wr.addr) == g)) begin
        gp_reg[g] <= spi_wr.data;
      end else if (av_wr.en && (int'(av_wr.addr) == g)) begin
        gp_reg[g] <= av_wr.data;
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_reg    <= MASK_RST;
      pin_sel_reg <= PINSEL_RST;
    end else begin
      if (spi_wr.en && (spi_wr.addr == REG_IRQ_MASK)) begin
        mask_reg <= spi_wr.data;
      end else if (av_wr.en && (av_wr.addr == REG_IRQ_MASK)) begin
        mask_reg <= av_wr.data;
      end
      // Only the select bit is stored; reserved bits are dropped
      if (spi_wr.en && (spi_wr.addr == REG_DAC_CTRL4)) begin
        pin_sel_reg <= spi_wr.data[IRQ_PIN_SEL_BIT];
      end else if (av_wr.en && (av_wr.addr == REG_DAC_CTRL4)) begin
        pin_sel_reg <= av_wr.data[IRQ_PIN_SEL_BIT];
      end
    end
  end

  // Sticky flags: a read clears, a new event in that cycle survives
  always_comb begin
    status_next  = status_reg;
    src_err_next = src_err_reg;
    rx_err_next  = rx_err_reg;
    if ((spi_rd_load && (spi_rd_addr == REG_IRQ_STATUS)) ||
        (av_rd_take && (avs_address_i == REG_IRQ_STATUS))) begin
      status_next = '0;
    end
    if ((spi_rd_load && (spi_rd_addr == REG_SRC_ERROR)) ||
        (av_rd_take && (avs_address_i == REG_SRC_ERROR))) begin
      src_err_next = '0;
    end
    if ((spi_rd_load && (spi_rd_addr == REG_RX_ERROR)) ||
        (av_rd_take && (avs_address_i == REG_RX_ERROR))) begin
      rx_err_next = '0;
    end
    src_err_next = src_err_next | evt_i.src;
    rx_err_next  = rx_err_next | evt_i.rx;
    status_next[STAT_SRC_ERR_BIT] = status_next[STAT_SRC_ERR_BIT] |
                                    (|evt_i.src);
    status_next[STAT_RX_ERR_BIT]  = status_next[STAT_RX_ERR_BIT] |
                                    (|evt_i.rx);
    status_next[DATA_W-1:STAT_MISC_LSB] =
      status_next[DATA_W-1:STAT_MISC_LSB] | evt_i.misc;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg  <= STATUS_RST;
      src_err_reg <= ERR_RST;
      rx_err_reg  <= ERR_RST;
    end else begin
      status_reg  <= status_next;
      src_err_reg <= src_err_next;
      rx_err_reg  <= rx_err_next;
    end
  end

  // Interrupt and dual-purpose pin, both registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o                  <= 1'b0;
      zero_left_or_irq_pin_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & mask_reg);
      zero_left_or_irq_pin_o <= pin_sel_reg ?
                                (|(status_reg & mask_reg)) :
                                zero_left_i;
    end
  end

endmodule

// ===== csp_checker.sv
// Purpose: Port assertions for the serial control port
// Assumes: Host leaves the latch high 7+ clk between frames
// Notes:   Bound into csp_ctrl_port below
`timescale 1ns/100ps
module csp_checker
  import csp_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ctrl_latch_n_i,
  input wire logic                 ctrl_serial_clock_i,
  input wire logic                 ctrl_serial_out_o,
  input wire logic                 ctrl_serial_out_oe_o,
  input wire logic                 avs_read_i,
  input wire logic                 avs_write_i,
  input wire logic [AV_DATA_W-1:0] avs_readdata_o,
  input wire logic                 zero_left_i,
  input wire logic                 irq_o,
  input wire logic                 zero_left_or_irq_pin_o
);
  logic seen_reg;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Masks stay zero until some write can land
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) seen_reg <= 1'b0;
    else if (avs_write_i || !ctrl_latch_n_i) seen_reg <= 1'b1;
  end
  readdata_hi_a: assert property (
    avs_readdata_o[31:8] == 24'h00_0000)
    else $error("readdata upper bits set");
  mask_gate_a: assert property (!seen_reg |-> !irq_o)
    else $error("irq with all masks clear");
  irq_hold_a: assert property (
    irq_o && !avs_read_i && !$past(avs_read_i) && !avs_write_i &&
    !$past(avs_write_i) && ctrl_latch_n_i && $past(ctrl_latch_n_i, 3)
    |=> irq_o)
    else $error("irq dropped without a read");
  pin_quiet_a: assert property (
    !irq_o && $past(!irq_o) && $past(!zero_left_i)
    |-> !zero_left_or_irq_pin_o)
    else $error("pin high with no source");
  oe_idle_a: assert property (
    ctrl_latch_n_i [*5] |-> !ctrl_serial_out_oe_o)
    else $error("serial out driven outside frame");
  oe_late_a: assert property (
    $fell(ctrl_latch_n_i) |=> !ctrl_serial_out_oe_o [*8])
    else $error("serial out driven too early");
  oe_stay_a: assert property (
    ctrl_serial_out_oe_o && !ctrl_latch_n_i |=> ctrl_serial_out_oe_o)
    else $error("serial out released in frame");
  out_edge_a: assert property (
    $changed(ctrl_serial_out_o) && ctrl_serial_out_oe_o &&
    $past(ctrl_serial_out_oe_o) |-> !$past(ctrl_serial_clock_i, 3))
    else $error("serial out moved off falling edge");
endmodule
bind csp_ctrl_port csp_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ctrl_latch_n_i(ctrl_latch_n_i),
  .ctrl_serial_clock_i(ctrl_serial_clock_i),
  .ctrl_serial_out_o(ctrl_serial_out_o),
  .ctrl_serial_out_oe_o(ctrl_serial_out_oe_o),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .zero_left_i(zero_left_i),
  .irq_o(irq_o), .zero_left_or_irq_pin_o(zero_left_or_irq_pin_o));

// ===== csp_host.sv
// Purpose: Host serial master model
// Assumes: 8 clk bit period, 200 ns at 40 MHz
// Notes:   Clock idles low and stands still between frames
`timescale 1ns/100ps
module csp_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic oe_i,
  output logic      latch_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  logic last_q = 1'b0;
  logic line;
  // Released line shows the inverse of its last value
  assign line = oe_i ? sdo_i : ~last_q;
  initial begin
    latch_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  always @(posedge clk_i) if (oe_i) last_q <= sdo_i;
  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = '0;
    @(posedge clk_i);
    latch_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      sclk_o <= 1'b0;
      sdi_o <= tx[n-1-i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      @(posedge clk_i);
      rx = {rx[30:0], line};
      repeat (2) @(posedge clk_i);
    end
    @(posedge clk_i);
    sclk_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    latch_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the serial control port
// Assumes: Host model owns the link pins
// Notes:   Expected register contents kept in exp_mem
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
  import csp_pkg::*;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            latch_n, sclk, sdi, sdo, oe, irq, pin, av_wait;
  logic            zl = 1'b0;
  logic            av_rd = 1'b0;
  logic            av_wr = 1'b0;
  logic [6:0]      av_a = 7'h00;
  logic [6:0]      a;
  logic [3:0]      av_be = 4'h0;
  logic [31:0]     av_wd = 32'h0000_0000;
  logic [31:0]     av_q, d, rx;
  logic [7:0]      rnd = 8'h26;
  logic [7:0]      exp_mem [16] = '{default: 8'h00};
  logic [6:0]      rl [7] = '{REG_IRQ_STATUS, REG_IRQ_MASK, REG_SRC_ERROR,
    REG_RX_ERROR, REG_DAC_CTRL4, 7'h30, 7'h03};
  csp_evt_t        evt = '0;
  int              err_count = 0;
  int              compares = 0;
  int              cyc = 0;
  always #12.5 clk_i = ~clk_i;
  csp_ctrl_port u_csp_ctrl_port (
    .clk_i(clk_i), .rst_i(rst_i), .ctrl_latch_n_i(latch_n),
    .ctrl_serial_clock_i(sclk), .ctrl_serial_in_i(sdi),
    .ctrl_serial_out_o(sdo), .ctrl_serial_out_oe_o(oe),
    .avs_address_i(av_a), .avs_read_i(av_rd), .avs_write_i(av_wr),
    .avs_writedata_i(av_wd), .avs_byteenable_i(av_be),
    .avs_readdata_o(av_q), .avs_waitrequest_o(av_wait), .evt_i(evt),
    .zero_left_i(zl), .irq_o(irq), .zero_left_or_irq_pin_o(pin));
  csp_host u_host (.clk_i(clk_i), .sdo_i(sdo), .oe_i(oe),
    .latch_n_o(latch_n), .sclk_o(sclk), .sdi_o(sdi));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] frm(input logic [6:0] ad, input logic w,
                                      input logic [7:0] dt);
    return {16'h0000, ad, w, dt};
  endfunction
  task automatic av(input logic w, input logic [6:0] ad,
                    input logic [7:0] wd, output logic [31:0] q);
    @(posedge clk_i);
    av_a <= ad;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= {24'h00_0000, wd};
    av_be <= (ad == 7'h03) ? 4'h0 : 4'hF;
    do @(posedge clk_i); while (av_wait !== 1'b0);
    q = av_q;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic pulse(input csp_evt_t e);
    @(posedge clk_i);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
    repeat (3) @(posedge clk_i);
  endtask
  task summarize();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ceiling sits well above the full sequence length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Unmapped write, and a write with lane 0 disabled at 0x03
    av(1'b1, 7'h30, 8'hA5, d);
    av(1'b1, 7'h03, 8'h5A, d);
    foreach (rl[i]) begin
      av(1'b0, rl[i], 8'h00, d);
      `CHK(d, 32'h0000_0000)
    end
    $display("test reset done");
    repeat (4) begin
      rnd = lfsr(rnd);
      a = {3'h0, rnd[3:0]};
      rnd = lfsr(rnd);
      exp_mem[a[3:0]] = rnd;
      u_host.xfer(16, frm(a, 1'b0, rnd), rx);
      av(1'b0, a, 8'h00, d);
      `CHK(d[7:0], exp_mem[a[3:0]])
      rnd = lfsr(rnd);
      // Lane 0 is off at 0x03, so that bus write must not land
      if (a != 7'h03) exp_mem[a[3:0]] = rnd;
      av(1'b1, a, rnd, d);
      u_host.xfer(16, frm(a, 1'b1, ~rnd), rx);
      `CHK(rx[7:0], exp_mem[a[3:0]])
      av(1'b0, a, 8'h00, d);
      `CHK(d[7:0], exp_mem[a[3:0]])
    end
    $display("test single done");
    u_host.xfer(24, {8'h00, 7'h0E, 1'b0, 16'hC33C}, rx);
    av(1'b0, 7'h0E, 8'h00, d);
    `CHK(d[7:0], 8'hC3)
    av(1'b0, 7'h0F, 8'h00, d);
    `CHK(d[7:0], 8'h3C)
    u_host.xfer(24, {8'h00, 7'h0E, 1'b1, 16'hFFFF}, rx);
    `CHK(rx[15:0], 16'hC33C)
    $display("test block done");
    // Frame cut after twelve bits, then a bus read-back of 0x02 and a clean frame
    u_host.xfer(12, {20'h0_0000, 7'h02, 1'b0, 4'hF}, rx);
    av(1'b0, 7'h02, 8'h00, d);
    `CHK(d[7:0], exp_mem[2])
    u_host.xfer(16, frm(7'h02, 1'b0, 8'h81), rx);
    av(1'b0, 7'h02, 8'h00, d);
    `CHK(d[7:0], 8'h81)
    $display("test abort done");
    zl <= rnd[0];
    pulse('{src: 8'h08, rx: 8'h00, misc: 6'h00});
    `CHK(irq, 1'b0)
    `CHK(pin, zl)
    av(1'b1, REG_IRQ_MASK, 8'h03, d);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b1)
    u_host.xfer(16, frm(REG_DAC_CTRL4, 1'b0, 8'h01), rx);
    repeat (3) @(posedge clk_i);
    `CHK(pin, 1'b1)
    av(1'b0, REG_SRC_ERROR, 8'h00, d);
    `CHK(d[7:0], 8'h08)
    av(1'b0, REG_SRC_ERROR, 8'h00, d);
    `CHK(d[7:0], 8'h00)
    `CHK(irq, 1'b1)
    av(1'b0, REG_IRQ_STATUS, 8'h00, d);
    `CHK(d[7:0], 8'h01)
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b0)
    `CHK(pin, 1'b0)
    pulse('{src: 8'h00, rx: 8'h01, misc: 6'h00});
    u_host.xfer(16, frm(REG_IRQ_STATUS, 1'b1, 8'hFF), rx);
    `CHK(rx[7:0], 8'h02)
    av(1'b0, REG_RX_ERROR, 8'h00, d);
    `CHK(d[7:0], 8'h01)
    av(1'b0, REG_IRQ_STATUS, 8'h00, d);
    `CHK(d[7:0], 8'h00)
    // Misc conditions stay masked but still latch in status
    pulse('{src: 8'h00, rx: 8'h00, misc: 6'h21});
    `CHK(irq, 1'b0)
    av(1'b0, REG_IRQ_STATUS, 8'h00, d);
    `CHK(d[7:0], 8'h84)
    $display("test irq done");
    summarize();
  end
endmodule
